// ==== rtl/tscw_ctrl.sv ====
`timescale 1ns/1ps
module tscw_ctrl import tscw_pkg::*; #(
    parameter int unsigned IDLE_CYC = 32'd2400000000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] ctrl_word_i,
    input wire logic ctrl_valid_i,
    input wire logic touch_i,
    input wire logic buz_stop_touch_i,
    input wire logic buz_cfg_en_i,
    input wire logic idle_off_en_i,
    input wire logic auto_off_i,
    input wire logic screen_new_i,
    input wire tscw_attr_t attr_i,
    output logic screen_on_o,
    output logic backlight_o,
    output logic buzzer_o,
    output logic prio_o,
    output logic [15:0] ctrl_word_o
);
    // Touch inputs arrive from panel pins: two-stage sync
    logic [1:0] touch_s1_q;
    logic [1:0] touch_s2_q;
    logic touch_s3_q;
    logic stop_s3_q;
    logic [15:0] ref_q;
    logic ref_ok_q;
    logic screen_q;
    logic dark_q;
    logic prio_q;
    logic flash_q;
    tscw_buz_t buz_q;
    tscw_buz_t buz_d;
    logic attr_flash_q;
    logic [31:0] idle_q;
    logic idle_off_q;
    tscw_out_t out_q;
    tscw_out_t out_d;
    logic buz_ph;
    logic fl_ph;

    wire logic [15:0] word_m = ctrl_word_i & CTRL_USED_MASK;
    wire logic take = ctrl_valid_i && ref_ok_q;
    wire logic [15:0] rise = take ? (word_m & ~ref_q) : 16'h0000;
    wire logic [15:0] fall = take ? (~word_m & ref_q) : 16'h0000;
    wire logic touch_rise = touch_s2_q[0] && !touch_s3_q;
    wire logic stop_rise = touch_s2_q[1] && !stop_s3_q;
    wire logic activity = touch_rise || stop_rise;
    wire logic idle_hit = idle_off_en_i && (idle_q == 32'(IDLE_CYC - 1));

    always_comb begin
        buz_d = buz_q;
        if (screen_new_i && attr_i.buz_en) begin
            buz_d = attr_i.buz_cont ? TSCW_BUZ_CONT : TSCW_BUZ_INT;
        end
        // Bit edges start and stop buzzers
        if (fall[BIT_BUZ_INT] && buz_q == TSCW_BUZ_INT) begin
            buz_d = TSCW_BUZ_OFF;
        end
        if (fall[BIT_BUZ_CONT] && buz_q == TSCW_BUZ_CONT) begin
            buz_d = TSCW_BUZ_OFF;
        end
        if (rise[BIT_BUZ_INT] && buz_q != TSCW_BUZ_CONT) begin
            buz_d = TSCW_BUZ_INT;
        end
        if (rise[BIT_BUZ_CONT] || (rise[BIT_BUZ_INT] &&
                word_m[BIT_BUZ_CONT])) begin
            buz_d = TSCW_BUZ_CONT;
        end
        if (stop_rise) begin
            buz_d = TSCW_BUZ_OFF;
        end
    end

    tscw_blink #(.HALF_CYC(BUZ_HALF_CYC)) u_buz_blink (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(buz_q == TSCW_BUZ_INT),
        .phase_o(buz_ph)
    );

    tscw_blink #(.HALF_CYC(FLASH_HALF_CYC)) u_flash_blink (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(flash_q || attr_flash_q),
        .phase_o(fl_ph)
    );

    always_comb begin
        out_d.screen_on = screen_q && !dark_q;
        out_d.backlight = screen_q && !dark_q && !idle_off_q;
        if (out_d.backlight && (flash_q || attr_flash_q)) begin
            out_d.backlight = fl_ph;
        end
        case (buz_q)
            TSCW_BUZ_CONT: out_d.buzzer = buz_cfg_en_i;
            TSCW_BUZ_INT: out_d.buzzer = buz_cfg_en_i && buz_ph;
            default: out_d.buzzer = 1'b0;
        endcase
        out_d.prio = prio_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            touch_s1_q <= 2'h0;
            touch_s2_q <= 2'h0;
            touch_s3_q <= 1'b0;
            stop_s3_q <= 1'b0;
        end else begin
            touch_s1_q <= {buz_stop_touch_i, touch_i};
            touch_s2_q <= touch_s1_q;
            touch_s3_q <= touch_s2_q[0];
            stop_s3_q <= touch_s2_q[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ref_q <= CTRL_RESET;
            ref_ok_q <= 1'b0;
        end else if (ctrl_valid_i) begin
            ref_q <= word_m;
            ref_ok_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            screen_q <= 1'b1;
            dark_q <= 1'b0;
        end else begin
            if (fall[BIT_SCREEN]) begin
                screen_q <= 1'b0;
            end else if (rise[BIT_SCREEN] || touch_rise) begin
                screen_q <= 1'b1;
            end
            // Auto-off cleared only by display bit toggle
            if (auto_off_i && screen_q) begin
                dark_q <= 1'b1;
            end else if (rise[BIT_SCREEN]) begin
                dark_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prio_q <= 1'b0;
            flash_q <= 1'b0;
            buz_q <= TSCW_BUZ_OFF;
            attr_flash_q <= 1'b0;
        end else begin
            if (rise[BIT_PRIO]) begin
                prio_q <= 1'b1;
            end else if (fall[BIT_PRIO]) begin
                prio_q <= 1'b0;
            end
            if (rise[BIT_FLASH]) begin
                flash_q <= 1'b1;
            end else if (fall[BIT_FLASH]) begin
                flash_q <= 1'b0;
            end
            buz_q <= buz_d;
            if (screen_new_i) begin
                attr_flash_q <= attr_i.flash;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idle_q <= 32'h0000_0000;
            idle_off_q <= 1'b0;
        end else begin
            // Idle timer, restarted by a rising edge on either touch input
            if (activity || !idle_off_en_i) begin
                idle_q <= 32'h0000_0000;
                idle_off_q <= 1'b0;
            end else if (idle_hit) begin
                idle_off_q <= 1'b1;
            end else if (!idle_off_q) begin
                idle_q <= idle_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign screen_on_o = out_q.screen_on;
    assign backlight_o = out_q.backlight;
    assign buzzer_o = out_q.buzzer;
    assign prio_o = out_q.prio;
    // Readback is the host's word, never local state
    assign ctrl_word_o = ref_q;
endmodule // tscw_ctrl

// ==== rtl/tscw_pkg.sv ====
package tscw_pkg;
    // Control word bit positions
    localparam int unsigned BIT_SCREEN = 15;
    localparam int unsigned BIT_PRIO = 14;
    localparam int unsigned BIT_BUZ_CONT = 13;
    localparam int unsigned BIT_BUZ_INT = 12;
    localparam int unsigned BIT_FLASH = 8;
    localparam logic [15:0] CTRL_USED_MASK = 16'hF100;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Timing
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned BUZ_HALF_MS = 500;
    localparam int unsigned BUZ_HALF_CYC = CLK_HZ / 1000 * BUZ_HALF_MS;
    localparam int unsigned FLASH_HALF_MS = 500;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

    typedef enum logic [1:0] {
        TSCW_BUZ_OFF,
        TSCW_BUZ_CONT,
        TSCW_BUZ_INT
    } tscw_buz_t;

    // Attributes of the screen being shown
    typedef struct packed {
        logic buz_en;
        logic buz_cont;
        logic flash;
    } tscw_attr_t;

    // Local panel outputs
    typedef struct packed {
        logic screen_on;
        logic backlight;
        logic buzzer;
        logic prio;
    } tscw_out_t;
endpackage

// ==== rtl/tscw_blink.sv ====
`timescale 1ns/1ps
module tscw_blink import tscw_pkg::*; #(
    parameter int unsigned HALF_CYC = BUZ_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic phase_o
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic phase_q;
    logic phase_d;
    wire logic wrap = (cnt_q == 32'(HALF_CYC - 1));

    // Restart on phase on each start so the first half-period is full
    assign cnt_d = (!run_i || wrap) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
    assign phase_d = !run_i ? 1'b1 : (wrap ? ~phase_q : phase_q);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 32'h0000_0000;
            phase_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
        end
    end

    assign phase_o = phase_q;
endmodule // tscw_blink

// ==== verification/tscw_host.sv ====
`timescale 1ns/1ps
// Host side: reads its shared memory word once every PERIOD cycles
module tscw_host import tscw_pkg::*; #(
    parameter int unsigned PERIOD = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] mem_word_i,
    input wire logic prio_i,
    output logic [15:0] ctrl_word_o,
    output logic ctrl_valid_o,
    output logic [15:0] port_stat_o
);
    logic [7:0] cnt_q;
    wire rd_now = (cnt_q == 8'(PERIOD - 1));
    // Word kept in its own area, read apart from notify
    // Outside a read the bus shows the inverse, never a stale word
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            ctrl_valid_o <= 1'b0;
        end else begin
            cnt_q <= rd_now ? 8'h00 : cnt_q + 8'h01;
            ctrl_valid_o <= rd_now;
        end
        ctrl_word_o <= rd_now ? mem_word_i : ~mem_word_i;
    end
    // Unit 0 alone: connected flag and latest priority flag
    assign port_stat_o = {7'h00, prio_i, 7'h00, 1'b1};
endmodule // tscw_host

// ==== verification/tscw_ctrl_sva.sv ====
`timescale 1ns/1ps
module tscw_ctrl_sva import tscw_pkg::*; #(
    parameter int unsigned IDLE_CYC = 100
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] ctrl_word_i,
    input wire logic ctrl_valid_i,
    input wire logic buz_stop_touch_i,
    input wire logic buz_cfg_en_i,
    input wire logic auto_off_i,
    input wire logic screen_on_o,
    input wire logic backlight_o,
    input wire logic buzzer_o,
    input wire logic prio_o,
    input wire logic [15:0] ctrl_word_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] ref_q;
    always_ff @(posedge clk_i) begin
        if (ctrl_valid_i) begin
            ref_q <= ctrl_word_i & CTRL_USED_MASK;
        end
    end
    spare_bits_a:
        assert property ((ctrl_word_o & ~CTRL_USED_MASK) == 16'h0000)
        else $error("unused control bits passed out");
    word_ref_a:
        assert property (ctrl_valid_i |=> ##[0:1] ctrl_word_o == ref_q)
        else $error("reference word not held");
    prio_rise_a:
        assert property ($rose(prio_o) |-> $past(ctrl_valid_i, 2)
            && $past(ctrl_word_i[14], 2))
        else $error("priority claimed without bit");
    prio_still_a:
        assert property (!$past(ctrl_valid_i, 2) |-> $stable(prio_o))
        else $error("priority moved without a read");
    cfg_gate_a:
        assert property (!buz_cfg_en_i [*4] |-> !buzzer_o)
        else $error("buzzer sounds while disabled");
    dark_unlit_a:
        assert property (!screen_on_o |-> !backlight_o)
        else $error("backlight lit on blank screen");
    stop_touch_a:
        assert property ($rose(buz_stop_touch_i) |-> ##8 !buzzer_o)
        else $error("stop touch left buzzer on");
    screen_drop_a:
        assert property ($fell(screen_on_o) |-> !ref_q[15]
            || $past(auto_off_i, 2) || $past(auto_off_i, 3))
        else $error("screen blanked without cause");
endmodule // tscw_ctrl_sva

bind tscw_ctrl tscw_ctrl_sva #(.IDLE_CYC(IDLE_CYC)) u_sva (.clk_i,
    .rst_n_i, .ctrl_word_i, .ctrl_valid_i, .buz_stop_touch_i, .buz_cfg_en_i,
    .auto_off_i, .screen_on_o, .backlight_o, .buzzer_o, .prio_o,
    .ctrl_word_o);

// ==== verification/terminal_status_control_word_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) \
    begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h, want %h", $time, (a), (b)); end end
module terminal_status_control_word_tb_top
    import tscw_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, touch = 1'b0, stop = 1'b0;
    logic cfg_en = 1'b1, idle_en = 1'b0, auto_off = 1'b0, scr_new = 1'b0;
    logic [15:0] mem_w = 16'h0000;
    tscw_attr_t attr = '0;
    logic [15:0] rd_w, w_o, stat, w, prev;
    logic rd_v, scr, bl, buz, prio, e_prio;
    int err_count = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    tscw_host #(.PERIOD(8)) u_host (.clk_i(clk), .rst_n_i(rst_n),
        .mem_word_i(mem_w), .prio_i(prio), .ctrl_word_o(rd_w),
        .ctrl_valid_o(rd_v), .port_stat_o(stat));
    tscw_ctrl #(.IDLE_CYC(100)) u_dut (.clk_i(clk), .rst_n_i(rst_n),
        .ctrl_word_i(rd_w), .ctrl_valid_i(rd_v), .touch_i(touch),
        .buz_stop_touch_i(stop), .buz_cfg_en_i(cfg_en),
        .idle_off_en_i(idle_en), .auto_off_i(auto_off),
        .screen_new_i(scr_new), .attr_i(attr), .screen_on_o(scr),
        .backlight_o(bl), .buzzer_o(buz), .prio_o(prio), .ctrl_word_o(w_o));
    // Action only when the bit moved, else keep the old state
    function automatic logic nxt(logic old, logic pb, logic nb);
        return (pb != nb) ? nb : old;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Long enough for the next host read plus two edges
    task automatic put(input logic [15:0] v);
        mem_w = v;
        tick(12);
    endtask
    task automatic hit(ref logic s);
        s = 1'b1;
        tick(10);
        s = 1'b0;
        tick(2);
    endtask
    task automatic conclude();
        if (err_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        tick(4000);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
    initial begin
        void'($urandom(97));
        w = 16'hF000 | (16'($urandom()) & 16'h0EFF);
        mem_w = w;
        tick(16);
        rst_n = 1'b1;
        tick(1);
        `CHK({scr, bl, buz, prio}, 4'hC)
        `CHK(w_o, CTRL_RESET)
        tick(12);
        `CHK({scr, bl, buz, prio}, 4'hC)
        `CHK(w_o, w & CTRL_USED_MASK)
        e_prio = 1'b0;
        for (int i = 0; i < 16; i++) begin
            prev = w;
            w = 16'h8000 | (16'($urandom()) & 16'h4EFF);
            put(w);
            e_prio = nxt(e_prio, prev[BIT_PRIO], w[BIT_PRIO]);
            `CHK({buz, prio}, {1'b0, e_prio})
            `CHK(w_o, w & CTRL_USED_MASK)
        end
        put(16'h8000);
        put(16'hA000);
        `CHK(buz, 1'b1)
        hit(stop);
        `CHK(buz, 1'b0)
        tick(12);
        `CHK(buz, 1'b0)
        put(16'h8000);
        put(16'hB000);
        repeat (8) begin
            tick(5);
            `CHK(buz, 1'b1)
        end
        cfg_en = 1'b0;
        tick(6);
        `CHK(buz, 1'b0)
        cfg_en = 1'b1;
        put(16'h9000);
        `CHK(buz, 1'b0)
        put(16'h8000);
        put(16'h9000);
        `CHK(buz, 1'b1)
        hit(stop);
        attr = 3'b110;
        scr_new = 1'b1;
        tick(1);
        scr_new = 1'b0;
        tick(8);
        `CHK(buz, 1'b1)
        hit(stop);
        put(16'h0000);
        `CHK({scr, bl}, 2'b00)
        put(16'h0100);
        `CHK(bl, 1'b0)
        hit(touch);
        `CHK({scr, bl}, 2'b11)
        put(16'h8000);
        put(16'h0000);
        put(16'h8000);
        `CHK({scr, bl}, 2'b11)
        auto_off = 1'b1;
        tick(6);
        auto_off = 1'b0;
        tick(4);
        `CHK(scr, 1'b0)
        // Host drops and raises the display bit to recover
        put(16'h0000);
        put(16'h8000);
        `CHK({scr, bl}, 2'b11)
        put(16'h8100);
        put(16'h8000);
        `CHK(bl, 1'b1)
        idle_en = 1'b1;
        tick(130);
        `CHK(bl, 1'b0)
        conclude();
    end
endmodule // terminal_status_control_word_tb_top
